// ===== sc_pkg.sv
// information-register map and constants of the slave controller core
// assumes byte-wide register access from the network side and local host side
package sc_pkg;

    // byte offsets of the information registers
    localparam logic [15:0] OFS_TYPE      = 16'h0000;
    localparam logic [15:0] OFS_REV       = 16'h0001;
    localparam logic [15:0] OFS_BUILD_LO  = 16'h0002;
    localparam logic [15:0] OFS_BUILD_HI  = 16'h0003;
    localparam logic [15:0] OFS_AMU_CNT   = 16'h0004;
    localparam logic [15:0] OFS_BSU_CNT   = 16'h0005;
    localparam logic [15:0] OFS_RAM_SIZE  = 16'h0006;
    localparam logic [15:0] OFS_PORT_DESC = 16'h0007;
    localparam logic [15:0] OFS_FEAT_LO   = 16'h0008;
    localparam logic [15:0] OFS_FEAT_HI   = 16'h0009;

    // repeated unit register sets
    localparam logic [15:0] AMU_BASE      = 16'h0600;
    localparam int          AMU_SET_BYTES = 16;
    localparam int          AMU_COUNT     = 3;
    localparam int          AMU_BYTES     = AMU_SET_BYTES * AMU_COUNT;
    localparam int          AMU_AW        = 6;
    localparam logic [15:0] BSU_BASE      = 16'h0800;
    localparam int          BSU_SET_BYTES = 8;
    localparam int          BSU_COUNT     = 4;
    localparam int          BSU_BYTES     = BSU_SET_BYTES * BSU_COUNT;
    localparam int          BSU_AW        = 5;

    // process data ram and the digital input overlay
    localparam logic [15:0] PRAM_BASE     = 16'h1000;
    localparam int          PRAM_BYTES    = 4096;
    localparam int          PRAM_AW       = 12;
    localparam logic [15:0] OFS_DIN_LO    = 16'h1000;
    localparam logic [15:0] OFS_DIN_HI    = 16'h1001;
    localparam int          DIN_W         = 16;

    // reset and constant values
    localparam logic [15:0] BUILD_RST     = 16'h0000;
    localparam logic [7:0]  AMU_CNT_VAL   = 8'h03;
    localparam logic [7:0]  BSU_CNT_VAL   = 8'h04;
    localparam logic [7:0]  RAM_SIZE_VAL  = 8'h04;
    localparam logic [15:0] FEAT_VAL      = 16'h01cc;

    // port descriptor field positions
    localparam int          PORT0_LSB     = 0;
    localparam int          PORT1_LSB     = 2;
    localparam int          PORT2_LSB     = 4;
    localparam int          PORT3_LSB     = 6;

    // cycles from reset release until the synchronised strap is valid
    localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

    typedef enum logic [1:0] {
        PORT_NOT_IMPL  = 2'b00,
        PORT_NOT_CFG   = 2'b01,
        PORT_BACKPLANE = 2'b10,
        PORT_MII       = 2'b11
    } sc_port_cfg_t;

endpackage

// ===== sc_sync2.sv
// two-flop synchroniser for asynchronous pin levels
// assumes one core clock; output is registered
`timescale 1ns/1ps
module sc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // meta_ff is read only by q_ff
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule // sc_sync2

// ===== sc_byte_store.sv
// byte array with two combinational read ports and two write ports
// assumes port a is the network side; its write wins on a collision
`timescale 1ns/1ps
module sc_byte_store #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic          clk,
    // port a
    input  wire logic          we_a,
    input  wire logic [AW-1:0] addr_a,
    input  wire logic [7:0]    wdata_a,
    output logic      [7:0]    rdata_a,
    // port b
    input  wire logic          we_b,
    input  wire logic [AW-1:0] addr_b,
    input  wire logic [7:0]    wdata_b,
    output logic      [7:0]    rdata_b
);
    logic [7:0] mem [DEPTH];

    // data storage, so no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (we_b) begin
            mem[addr_b] <= wdata_b;
        end
        if (we_a) begin
            mem[addr_a] <= wdata_a;
        end
    end

    assign rdata_a = mem[addr_a];
    assign rdata_b = mem[addr_b];
endmodule // sc_byte_store

// ===== sc_info_regs.sv
// information registers and map decode of the slave controller core
// assumes byte requests from network side and local host side on clk
//
// Notes on behaviour
// - controller type at offset zero, revision next byte, both constant.
// - build field sixteen bits, read only, reads all zeros.
// - mapping-unit count register always reads three.
// - buffer-sync-unit count register always reads four.
// - ram size register reads four, meaning four kilobytes.
// - port descriptor holds four two-bit fields, port 0 lowest.
// - port 3 reads not implemented; ports 0 and 1 read mii.
// - port 2 reads mii in three-port mode, else not configured.
// - multi-byte registers put the low byte at the lowest address.
// - three mapping-unit sets of sixteen bytes from their base.
// - four buffer-sync sets of eight bytes from their base.
// - digital input data overlays the first two process ram bytes.
// - network side and local host side have their own access path.
`timescale 1ns/1ps
module sc_info_regs
    import sc_pkg::*;
#(
    // arbitrary identity values
    parameter logic [7:0] CTRL_TYPE = 8'h5a,
    parameter logic [7:0] CTRL_REV  = 8'h01
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // network side access
    input  wire logic        net_rd,
    input  wire logic        net_wr,
    input  wire logic [15:0] net_addr,
    input  wire logic [7:0]  net_wdata,
    output logic      [7:0]  net_rdata,
    output logic             net_rvalid,
    // local host side access
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic [15:0] host_addr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    output logic             host_rvalid,
    // pins
    input  wire logic        three_port_pin,
    input  wire logic [15:0] digital_in_pin
);
    logic [1:0]       side_rd;
    logic [1:0]       side_wr;
    logic [15:0]      side_addr [2];
    logic [7:0]       side_wdata [2];
    logic [7:0]       rdata_ff [2];
    logic [1:0]       rvalid_ff;
    logic [7:0]       nxt_rdata [2];
    logic [1:0]       amu_hit;
    logic [1:0]       bsu_hit;
    logic [1:0]       pram_hit;
    logic [1:0]       din_hit;
    logic [7:0]       amu_q [2];
    logic [7:0]       bsu_q [2];
    logic [7:0]       pram_q [2];
    logic [AMU_AW-1:0]  amu_ofs [2];
    logic [BSU_AW-1:0]  bsu_ofs [2];
    logic [PRAM_AW-1:0] pram_ofs [2];
    logic             strap_q;
    logic [DIN_W-1:0] din_q;
    logic [1:0]       settle_ff;
    logic             three_port_ff;
    logic [7:0]       port_desc;

    // side 0 is the network side, side 1 the local host side
    assign side_rd       = {host_rd, net_rd};
    assign side_wr       = {host_wr, net_wr};
    assign side_addr[0]  = net_addr;
    assign side_addr[1]  = host_addr;
    assign side_wdata[0] = net_wdata;
    assign side_wdata[1] = host_wdata;

    sc_sync2 #(.W(1)) u_strap_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (three_port_pin),
        .q     (strap_q)
    );

    sc_sync2 #(.W(DIN_W)) u_din_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (digital_in_pin),
        .q     (din_q)
    );

    // the strap is caught once the sync chain holds a post-reset sample
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle_ff     <= 2'h0;
            three_port_ff <= 1'b0;
        end else if (settle_ff != STRAP_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == STRAP_SETTLE - 2'h1) begin
                three_port_ff <= strap_q;
            end
        end
    end

    always_comb begin
        port_desc = 8'h00;
        port_desc[PORT0_LSB +: 2] = PORT_MII;
        port_desc[PORT1_LSB +: 2] = PORT_MII;
        port_desc[PORT2_LSB +: 2] = three_port_ff ? PORT_MII
                                                  : PORT_NOT_CFG;
        port_desc[PORT3_LSB +: 2] = PORT_NOT_IMPL;
    end

    // both access paths share the decode; info bytes are read only on both
    generate
        for (genvar s = 0; s < 2; s++) begin : g_side
            always_comb begin
                amu_hit[s]  = (side_addr[s] >= AMU_BASE) &&
                    (side_addr[s] < AMU_BASE + 16'(AMU_BYTES));
                bsu_hit[s]  = (side_addr[s] >= BSU_BASE) &&
                    (side_addr[s] < BSU_BASE + 16'(BSU_BYTES));
                pram_hit[s] = (side_addr[s] >= PRAM_BASE) &&
                    (side_addr[s] < PRAM_BASE + 16'(PRAM_BYTES));
                din_hit[s]  = (side_addr[s] == OFS_DIN_LO) ||
                    (side_addr[s] == OFS_DIN_HI);
                amu_ofs[s]  = AMU_AW'(side_addr[s] - AMU_BASE);
                bsu_ofs[s]  = BSU_AW'(side_addr[s] - BSU_BASE);
                pram_ofs[s] = PRAM_AW'(side_addr[s] - PRAM_BASE);
            end

            always_comb begin
                if (side_addr[s] == OFS_TYPE) begin
                    nxt_rdata[s] = CTRL_TYPE;
                end else if (side_addr[s] == OFS_REV) begin
                    nxt_rdata[s] = CTRL_REV;
                end else if (side_addr[s] == OFS_BUILD_LO) begin
                    nxt_rdata[s] = BUILD_RST[7:0];
                end else if (side_addr[s] == OFS_BUILD_HI) begin
                    nxt_rdata[s] = BUILD_RST[15:8];
                end else if (side_addr[s] == OFS_AMU_CNT) begin
                    nxt_rdata[s] = AMU_CNT_VAL;
                end else if (side_addr[s] == OFS_BSU_CNT) begin
                    nxt_rdata[s] = BSU_CNT_VAL;
                end else if (side_addr[s] == OFS_RAM_SIZE) begin
                    nxt_rdata[s] = RAM_SIZE_VAL;
                end else if (side_addr[s] == OFS_PORT_DESC) begin
                    nxt_rdata[s] = port_desc;
                end else if (side_addr[s] == OFS_FEAT_LO) begin
                    nxt_rdata[s] = FEAT_VAL[7:0];
                end else if (side_addr[s] == OFS_FEAT_HI) begin
                    nxt_rdata[s] = FEAT_VAL[15:8];
                end else if (amu_hit[s]) begin
                    nxt_rdata[s] = amu_q[s];
                end else if (bsu_hit[s]) begin
                    nxt_rdata[s] = bsu_q[s];
                end else if (side_addr[s] == OFS_DIN_LO) begin
                    nxt_rdata[s] = din_q[7:0];
                end else if (side_addr[s] == OFS_DIN_HI) begin
                    nxt_rdata[s] = din_q[15:8];
                end else if (pram_hit[s]) begin
                    nxt_rdata[s] = pram_q[s];
                end else begin
                    // unimplemented space reads zero
                    nxt_rdata[s] = 8'h00;
                end
            end

            // a write needs no answer; writes to info bytes fall through
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    rdata_ff[s]  <= 8'h00;
                    rvalid_ff[s] <= 1'b0;
                end else begin
                    rvalid_ff[s] <= side_rd[s];
                    if (side_rd[s]) begin
                        rdata_ff[s] <= nxt_rdata[s];
                    end
                end
            end
        end
    endgenerate

    // only storage windows take writes; the info block has no write path
    sc_byte_store #(.DEPTH(AMU_BYTES), .AW(AMU_AW)) u_amu_store (
        .clk     (clk),
        .we_a    (net_wr && amu_hit[0]),
        .addr_a  (amu_ofs[0]),
        .wdata_a (net_wdata),
        .rdata_a (amu_q[0]),
        .we_b    (host_wr && amu_hit[1]),
        .addr_b  (amu_ofs[1]),
        .wdata_b (host_wdata),
        .rdata_b (amu_q[1])
    );

    sc_byte_store #(.DEPTH(BSU_BYTES), .AW(BSU_AW)) u_bsu_store (
        .clk     (clk),
        .we_a    (net_wr && bsu_hit[0]),
        .addr_a  (bsu_ofs[0]),
        .wdata_a (net_wdata),
        .rdata_a (bsu_q[0]),
        .we_b    (host_wr && bsu_hit[1]),
        .addr_b  (bsu_ofs[1]),
        .wdata_b (host_wdata),
        .rdata_b (bsu_q[1])
    );

    // input overlay bytes are not writable; the ram behind them is hidden
    sc_byte_store #(.DEPTH(PRAM_BYTES), .AW(PRAM_AW)) u_pram_store (
        .clk     (clk),
        .we_a    (net_wr && pram_hit[0] && !din_hit[0]),
        .addr_a  (pram_ofs[0]),
        .wdata_a (net_wdata),
        .rdata_a (pram_q[0]),
        .we_b    (host_wr && pram_hit[1] && !din_hit[1]),
        .addr_b  (pram_ofs[1]),
        .wdata_b (host_wdata),
        .rdata_b (pram_q[1])
    );

    assign net_rdata   = rdata_ff[0];
    assign net_rvalid  = rvalid_ff[0];
    assign host_rdata  = rdata_ff[1];
    assign host_rvalid = rvalid_ff[1];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_type_read: assert property (
        host_rd && host_addr == OFS_TYPE |=>
            host_rvalid && host_rdata == CTRL_TYPE)
        else $error("type byte wrong");

    chk_build_zero: assert property (
        net_rd && (net_addr == OFS_BUILD_LO || net_addr == OFS_BUILD_HI)
            |=> net_rvalid && net_rdata == 8'h00)
        else $error("build byte not zero");

    chk_amu_count: assert property (
        net_rd && net_addr == OFS_AMU_CNT |=> net_rdata == 8'h03)
        else $error("mapping unit count wrong");

    chk_bsu_count: assert property (
        host_rd && host_addr == OFS_BSU_CNT |=> host_rdata == 8'h04)
        else $error("sync unit count wrong");

    chk_ram_size: assert property (
        net_rd && net_addr == OFS_RAM_SIZE |=> net_rdata == 8'h04)
        else $error("ram size wrong");

    chk_port_fixed: assert property (
        host_rd && host_addr == OFS_PORT_DESC |=>
            host_rdata[7:6] == 2'b00 && host_rdata[3:0] == 4'hf)
        else $error("fixed port fields wrong");

    chk_port2_mode: assert property (
        net_rd && net_addr == OFS_PORT_DESC |=>
            net_rdata[5:4] == ($past(three_port_ff) ? 2'b11 : 2'b01))
        else $error("port 2 field wrong");

    chk_feat_order: assert property (
        host_rd && host_addr == OFS_FEAT_HI |=> host_rdata == 8'h01)
        else $error("high byte not at high address");

    sequence s_info_write;
        net_wr && net_addr == OFS_RAM_SIZE && net_wdata != 8'h04;
    endsequence
    sequence s_info_reread;
        net_rd && net_addr == OFS_RAM_SIZE;
    endsequence
    // a requester may read back on the next edge or leave one idle edge
    chk_write_ignored: assert property (
        s_info_write ##[1:2] s_info_reread |=> net_rdata == 8'h04)
        else $error("info write took effect");

    sequence s_amu_write;
        host_wr && host_addr >= AMU_BASE &&
            host_addr < AMU_BASE + 16'(AMU_BYTES) && !net_wr;
    endsequence
    sequence s_bsu_write;
        host_wr && host_addr >= BSU_BASE &&
            host_addr < BSU_BASE + 16'(BSU_BYTES) && !net_wr;
    endsequence
    sequence s_host_reread;
        host_rd && host_addr == $past(host_addr, 2) && !net_wr;
    endsequence
    // the idle edge between write and read must not carry another write
    chk_amu_store: assert property (
        s_amu_write ##1 (!net_wr && !host_wr) ##1 s_host_reread |=>
            host_rdata == $past(host_wdata, 3))
        else $error("mapping unit byte lost");

    chk_bsu_store: assert property (
        s_bsu_write ##1 (!net_wr && !host_wr) ##1 s_host_reread |=>
            host_rdata == $past(host_wdata, 3))
        else $error("sync unit byte lost");

    chk_din_overlay: assert property (
        host_rd && host_addr == OFS_DIN_LO |=>
            host_rdata == $past(din_q[7:0]))
        else $error("digital input overlay wrong");

    chk_net_answer: assert property (
        net_rd |=> net_rvalid)
        else $error("network read not answered");

    chk_host_answer: assert property (
        host_rd |=> host_rvalid)
        else $error("host read not answered");

endmodule // sc_info_regs

// ===== sc_bus_model.sv
// byte-wide requester standing in for the network master or the local host
// assumes the block answers a read one cycle after the request edge
`timescale 1ns/1ps
module sc_bus_model (
    // clock
    input  wire logic        clk,
    // request lines
    output logic             rd,
    output logic             wr,
    output logic      [15:0] addr,
    output logic      [7:0]  wdata,
    // answer lines
    input  wire logic [7:0]  rdata,
    input  wire logic        rvalid,
    // a bounded wait ran out
    output logic             hung
);
    initial begin
        rd    = 1'b0;
        wr    = 1'b0;
        addr  = 16'hffff;
        wdata = 8'hff;
        hung  = 1'b0;
    end

    // each side owns its request lines; nothing is shared between them
    task automatic rd_byte(input logic [15:0] a,
                           output logic [7:0] d);
        int n;
        d = 8'h00;
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        // released lines must not keep the old address
        addr <= ~a;
        #1;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (rvalid === 1'b1) begin
            d = rdata;
        end else begin
            // blocking, so the caller sees it as soon as the task returns
            hung = 1'b1;
        end
    endtask

    task automatic wr_byte(input logic [15:0] a,
                           input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask
endmodule // sc_bus_model

// ===== sc_info_regs_tb.sv
// self-checking bench of the information registers and map decode
// assumes two bus models, one per side, and pins driven by the bench
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    $display("wrong value %s expected %h seen %h", nm, exp, got); \
    n_mismatch++; end end
module sc_info_regs_tb
    import sc_pkg::*;
;
    // arbitrary identity values
    localparam logic [7:0] TYPE_ID = 8'h3c;
    localparam logic [7:0] REV_ID  = 8'h07;

    logic        clk;
    logic        rst_b;
    logic        three_port_pin;
    logic [15:0] digital_in_pin;
    logic        net_rd, net_wr, net_rvalid, net_hung;
    logic        host_rd, host_wr, host_rvalid, host_hung;
    logic [15:0] net_addr, host_addr;
    logic [7:0]  net_wdata, net_rdata, host_wdata, host_rdata;
    int          n_mismatch = 0;
    int          cmp_count  = 0;

    sc_info_regs #(
        .CTRL_TYPE (TYPE_ID),
        .CTRL_REV  (REV_ID)
    ) sc_info_regs_i (
        .clk            (clk),
        .rst_b          (rst_b),
        .net_rd         (net_rd),
        .net_wr         (net_wr),
        .net_addr       (net_addr),
        .net_wdata      (net_wdata),
        .net_rdata      (net_rdata),
        .net_rvalid     (net_rvalid),
        .host_rd        (host_rd),
        .host_wr        (host_wr),
        .host_addr      (host_addr),
        .host_wdata     (host_wdata),
        .host_rdata     (host_rdata),
        .host_rvalid    (host_rvalid),
        .three_port_pin (three_port_pin),
        .digital_in_pin (digital_in_pin)
    );

    sc_bus_model net_model (
        .clk (clk), .rd (net_rd), .wr (net_wr), .addr (net_addr),
        .wdata (net_wdata), .rdata (net_rdata), .rvalid (net_rvalid),
        .hung (net_hung)
    );

    sc_bus_model host_model (
        .clk (clk), .rd (host_rd), .wr (host_wr), .addr (host_addr),
        .wdata (host_wdata), .rdata (host_rdata), .rvalid (host_rvalid),
        .hung (host_hung)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // h selects the local host side, else the network side
    task automatic rd(input bit h, input logic [15:0] a, output logic [7:0] d);
        if (h) host_model.rd_byte(a, d);
        else net_model.rd_byte(a, d);
        if (net_hung === 1'b1 || host_hung === 1'b1) begin
            n_mismatch++;
            results();
        end
    endtask

    task automatic wr(input bit h, input logic [15:0] a, input logic [7:0] d);
        if (h) host_model.wr_byte(a, d);
        else net_model.wr_byte(a, d);
    endtask

    task automatic do_reset(input logic pin);
        @(posedge clk);
        rst_b          <= 1'b0;
        three_port_pin <= pin;
        repeat (3) @(posedge clk);
        #1;
        `CHK("rvalid in reset", 1'b0, net_rvalid)
        `CHK("rdata in reset", 8'h00, host_rdata)
        @(posedge clk);
        rst_b <= 1'b1;
        // strap is caught on the third edge after release
        repeat (6) @(posedge clk);
    endtask

    task automatic check_info(input logic three);
        logic [7:0]   e [10];
        logic [7:0]   g;
        sc_port_cfg_t p2;
        p2 = three ? PORT_MII : PORT_NOT_CFG;
        e  = '{TYPE_ID, REV_ID, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04,
               {PORT_NOT_IMPL, p2, PORT_MII, PORT_MII},
               FEAT_VAL[7:0], FEAT_VAL[15:8]};
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 10; i++) begin
                rd(s[0], 16'(i), g);
                if (i < 2) `CHK("ident", e[i], g)
                else if (i < 4) `CHK("build", e[i], g)
                else if (i < 6) `CHK("counts", e[i], g)
                else if (i < 7) `CHK("ram size", e[i], g)
                else if (i < 8) `CHK("port", e[i], g)
                else `CHK("features", e[i], g)
            end
        end
    endtask

    task automatic check_write_ignored();
        logic [7:0] g;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 10; i++) wr(s[0], 16'(i), 8'hff ^ 8'(i));
            wr(s[0], 16'h1000, 8'h77);
            wr(s[0], 16'h1001, 8'h77);
        end
        // read straight back after the write
        wr(1'b0, OFS_RAM_SIZE, 8'h5b);
        rd(1'b0, OFS_RAM_SIZE, g);
        `CHK("ram size after write", RAM_SIZE_VAL, g)
        check_info(1'b1);
    endtask

    // all sets are written before any is read, so aliasing shows up
    task automatic unit_sets(input logic [15:0] base, input int n,
                             input int sz);
        logic [7:0] g;
        for (int i = 0; i < n; i++) begin
            wr(1'b0, base + 16'(sz * i), 8'h40 + 8'(i));
            wr(1'b1, base + 16'(sz * i + sz - 1), 8'h80 + 8'(i));
        end
        wr(1'b0, base + 16'(sz * n), 8'h5e);
        for (int i = 0; i < n; i++) begin
            rd(1'b1, base + 16'(sz * i), g);
            `CHK("set first", 8'h40 + 8'(i), g)
            rd(1'b0, base + 16'(sz * i + sz - 1), g);
            `CHK("set last", 8'h80 + 8'(i), g)
        end
        rd(1'b1, base + 16'(sz * n), g);
        `CHK("past last set", 8'h00, g)
        // one side writes and reads back the same byte
        wr(1'b1, base + 16'h0001, 8'h3a);
        rd(1'b1, base + 16'h0001, g);
        `CHK("set rewrite", 8'h3a, g)
    endtask

    task automatic check_din();
        logic [7:0] g;
        @(posedge clk);
        digital_in_pin <= 16'hc3a5;
        repeat (4) @(posedge clk);
        rd(1'b1, 16'h1000, g);
        `CHK("din low", 8'ha5, g)
        rd(1'b0, 16'h1001, g);
        `CHK("din high", 8'hc3, g)
        wr(1'b1, 16'h1002, 8'h6d);
        wr(1'b0, 16'h1fff, 8'h92);
        rd(1'b0, 16'h1002, g);
        `CHK("ram after din", 8'h6d, g)
        rd(1'b1, 16'h1fff, g);
        `CHK("ram top", 8'h92, g)
    endtask

    initial begin
        rst_b          = 1'b0;
        three_port_pin = 1'b1;
        digital_in_pin = 16'h0000;
        do_reset(1'b1);
        check_info(1'b1);
        check_write_ignored();
        unit_sets(16'h0600, 3, 16);
        unit_sets(16'h0800, 4, 8);
        check_din();
        do_reset(1'b0);
        check_info(1'b0);
        results();
    end
endmodule // sc_info_regs_tb
